// File: core/asmcp_parser.sv
// Behaviour
// R01 - Accept ASCII commands over serial; keywords match in either letter case.
// R02 - Messages up to eight characters (64 bits) are handled; longer answer NO.
// R03 - Enabled from startup, disabled while config tool connected, re-enabled after.
// R04 - Host waits at least 1 ms between commands.
// R05 - Serial link is 8 data bits, 1 stop, no parity, 256000 bps, no CTS.
// R06 - Host ends every command with CR then LF.
// R07 - start answers OK CR LF and moves nothing.
// R08 - x= value sets X position and answers OK.
// R09 - y= value sets Y position and answers OK.
// R10 - xy= a;b sets both axes at once and answers OK.
// R11 - Values above one answer OU, below minus one answer OL.
// R12 - Unrecognised command answers NO CR LF.
// R13 - Each CR LF ends a command and yields exactly one reply line; a line ended while a reply is still being sent gets no reply.
`timescale 1ns/100ps
`default_nettype none

module asmcp_parser #(
   parameter int unsigned BAUD_DIV = asmcp_pkg::BIT_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_rx,
   input wire logic i_tool_connected,
   output logic o_tx,
   output logic [15:0] o_x_pos,
   output logic [15:0] o_y_pos,
   output logic o_pos_strobe,
   output logic o_enabled
);

   logic [7:0] rx_data;
   logic rx_valid;
   logic t1_reg, t2_reg, t3_reg, en_reg;
   asmcp_pkg::asmcp_pstate_t st_reg, st_next;
   asmcp_pkg::asmcp_cmd_t cmd_reg, cmd_next;
   asmcp_pkg::asmcp_reply_t reply_sel, code_reg;
   logic [39:0] kw_reg, kw_next;
   logic [3:0] len_reg, len_next;
   logic bad_reg, bad_next, sec_reg, sec_next, neg_reg, neg_next, neg1_reg, neg1_next;
   logic dot_reg, dot_next, dig_reg, dig_next, sgn_reg, sgn_next;
   logic [17:0] mag_reg, mag_next, mag1_reg, mag1_next;
   logic [2:0] nfr_reg, nfr_next;
   logic err, num_clr;
   logic busy_reg;
   logic [1:0] idx_reg;
   logic [3:0] nbit_reg;
   logic [15:0] bcnt_reg;
   logic [9:0] shift_reg;
   logic [7:0] tx_char;

   asmcp_uart_rx #(.BAUD_DIV(BAUD_DIV)) u_rx (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_rx(i_rx),
      .o_data(rx_data),
      .o_valid(rx_valid)
   );

   ////////////////////////////////////////////////////////////////////////
   // Character decode.
   wire is_up = (rx_data >= asmcp_pkg::CHR_UA) && (rx_data <= asmcp_pkg::CHR_UZ);
   wire [7:0] ch = is_up ? (rx_data | asmcp_pkg::CASE_BIT) : rx_data;  // R01
   wire is_let = (ch >= asmcp_pkg::CHR_LA) && (ch <= asmcp_pkg::CHR_LZ);
   wire is_dig = (ch >= asmcp_pkg::CHR_D0) && (ch <= asmcp_pkg::CHR_D9);
   wire is_crlf = (ch == asmcp_pkg::CHR_CR) || (ch == asmcp_pkg::CHR_LF);
   wire [17:0] dval = {14'h0000, ch[3:0]};
   wire line_done = rx_valid && en_reg && (st_reg == asmcp_pkg::PS_LF) &&
                    (ch == asmcp_pkg::CHR_LF);  // R06 R13
   wire too_long = (len_reg > asmcp_pkg::MAX_CHARS);  // R02
   wire hi_a = !neg_reg && (mag_reg > asmcp_pkg::POS_FULL);
   wire lo_a = neg_reg && (mag_reg > asmcp_pkg::POS_FULL);
   wire hi_b = !neg1_reg && (mag1_reg > asmcp_pkg::POS_FULL);
   wire lo_b = neg1_reg && (mag1_reg > asmcp_pkg::POS_FULL);
   wire [15:0] val_a = neg_reg ? 16'(-mag_reg[15:0]) : mag_reg[15:0];
   wire [15:0] val_b = neg1_reg ? 16'(-mag1_reg[15:0]) : mag1_reg[15:0];
   wire set_ok = line_done && (reply_sel == asmcp_pkg::RPL_OK);
   wire set_x = set_ok && ((cmd_reg == asmcp_pkg::CMD_X) || (cmd_reg == asmcp_pkg::CMD_XY));
   wire set_y = set_ok && ((cmd_reg == asmcp_pkg::CMD_Y) || (cmd_reg == asmcp_pkg::CMD_XY));
   wire [15:0] val_x = (cmd_reg == asmcp_pkg::CMD_XY) ? val_b : val_a;
   wire tx_go = line_done && !busy_reg;
   wire bit_end = busy_reg && (bcnt_reg == 16'(BAUD_DIV - 1));
   wire [1:0] ld_idx = tx_go ? 2'b00 : 2'(idx_reg + 2'b01);
   wire asmcp_pkg::asmcp_reply_t ld_code = tx_go ? reply_sel : code_reg;

   ////////////////////////////////////////////////////////////////////////
   // Reply selection for the completed line.
   always_comb begin
      if (bad_reg || too_long || (cmd_reg == asmcp_pkg::CMD_NONE)) begin
         reply_sel = asmcp_pkg::RPL_NO;  // R12 R02
      end else if (cmd_reg == asmcp_pkg::CMD_START) begin
         reply_sel = asmcp_pkg::RPL_OK;  // R07
      end else if ((cmd_reg == asmcp_pkg::CMD_XY) && hi_b) begin
         reply_sel = asmcp_pkg::RPL_OU;  // R11
      end else if ((cmd_reg == asmcp_pkg::CMD_XY) && lo_b) begin
         reply_sel = asmcp_pkg::RPL_OL;  // R11
      end else if (hi_a) begin
         reply_sel = asmcp_pkg::RPL_OU;  // R11
      end else if (lo_a) begin
         reply_sel = asmcp_pkg::RPL_OL;  // R11
      end else begin
         reply_sel = asmcp_pkg::RPL_OK;  // R08 R09 R10
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per character parsing.
   always_comb begin
      st_next = st_reg;
      cmd_next = cmd_reg;
      kw_next = kw_reg;
      len_next = len_reg;
      bad_next = bad_reg;
      sec_next = sec_reg;
      neg_next = neg_reg;
      mag_next = mag_reg;
      nfr_next = nfr_reg;
      dot_next = dot_reg;
      dig_next = dig_reg;
      sgn_next = sgn_reg;
      neg1_next = neg1_reg;
      mag1_next = mag1_reg;
      err = 1'b0;
      num_clr = 1'b0;
      if (!en_reg || line_done) begin
         st_next = asmcp_pkg::PS_KEY;  // R03 R13
         cmd_next = asmcp_pkg::CMD_NONE;
         kw_next = '0;
         len_next = 4'h0;
         bad_next = 1'b0;
         sec_next = 1'b0;
         num_clr = 1'b1;
      end else if (rx_valid) begin
         if (!is_crlf && (len_reg <= asmcp_pkg::MAX_CHARS)) begin
            len_next = len_reg + 4'h1;  // R02
         end
         unique case (st_reg)
            asmcp_pkg::PS_KEY: begin
               if (ch == asmcp_pkg::CHR_CR) begin
                  st_next = asmcp_pkg::PS_LF;
                  if (kw_reg == asmcp_pkg::KW_START) begin
                     cmd_next = asmcp_pkg::CMD_START;  // R07
                  end
               end else if (ch == asmcp_pkg::CHR_EQ) begin
                  st_next = asmcp_pkg::PS_NUM;
                  num_clr = 1'b1;
                  if (kw_reg == asmcp_pkg::KW_X) begin
                     cmd_next = asmcp_pkg::CMD_X;  // R08
                  end else if (kw_reg == asmcp_pkg::KW_Y) begin
                     cmd_next = asmcp_pkg::CMD_Y;  // R09
                  end else if (kw_reg == asmcp_pkg::KW_XY) begin
                     cmd_next = asmcp_pkg::CMD_XY;  // R10
                  end else begin
                     err = 1'b1;  // R12
                  end
               end else if (is_let && (kw_reg[39:32] == 8'h00)) begin
                  kw_next = {kw_reg[31:0], ch};  // R01
               end else begin
                  err = 1'b1;  // R12
               end
            end
            asmcp_pkg::PS_NUM: begin
               if (is_dig && dot_reg) begin
                  dig_next = 1'b1;
                  if (nfr_reg < asmcp_pkg::FRAC_DIGITS) begin
                     mag_next = 18'(mag_reg + dval * asmcp_pkg::FRAC_W[nfr_reg[1:0]]);
                     nfr_next = nfr_reg + 3'h1;
                  end
               end else if (is_dig) begin
                  dig_next = 1'b1;
                  if (mag_reg <= asmcp_pkg::POS_FULL) begin
                     mag_next = 18'(mag_reg * asmcp_pkg::DEC_BASE + dval * asmcp_pkg::POS_FULL);
                  end
               end else if (ch == asmcp_pkg::CHR_DOT) begin
                  err = dot_reg;
                  dot_next = 1'b1;
               end else if ((ch == asmcp_pkg::CHR_MINUS) || (ch == asmcp_pkg::CHR_PLUS)) begin
                  err = dig_reg || dot_reg || sgn_reg;
                  sgn_next = 1'b1;
                  neg_next = (ch == asmcp_pkg::CHR_MINUS);
               end else if (ch == asmcp_pkg::CHR_SPACE) begin
                  err = dig_reg || dot_reg || sgn_reg;
               end else if (ch == asmcp_pkg::CHR_SEMI) begin
                  err = (cmd_reg != asmcp_pkg::CMD_XY) || sec_reg || !dig_reg;  // R10
                  sec_next = 1'b1;
                  neg1_next = neg_reg;
                  mag1_next = mag_reg;
                  num_clr = 1'b1;
               end else if (ch == asmcp_pkg::CHR_CR) begin
                  st_next = asmcp_pkg::PS_LF;
                  if (!dig_reg || ((cmd_reg == asmcp_pkg::CMD_XY) && !sec_reg)) begin
                     bad_next = 1'b1;  // R12
                  end
               end else begin
                  err = 1'b1;  // R12
               end
            end
            asmcp_pkg::PS_SKIP: begin
               if (ch == asmcp_pkg::CHR_CR) begin
                  st_next = asmcp_pkg::PS_LF;
               end
            end
            asmcp_pkg::PS_LF: begin
               err = (ch != asmcp_pkg::CHR_CR);  // R06
            end
         endcase
         if (err) begin
            bad_next = 1'b1;
            st_next = asmcp_pkg::PS_SKIP;
         end
      end
      if (num_clr) begin
         neg_next = 1'b0;
         mag_next = '0;
         nfr_next = 3'h0;
         dot_next = 1'b0;
         dig_next = 1'b0;
         sgn_next = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reply characters.
   always_comb begin
      unique case (ld_idx)
         2'b00: tx_char = (ld_code == asmcp_pkg::RPL_NO) ? asmcp_pkg::CHR_N : asmcp_pkg::CHR_O;
         2'b01: begin
            unique case (ld_code)
               asmcp_pkg::RPL_OK: tx_char = asmcp_pkg::CHR_K;
               asmcp_pkg::RPL_NO: tx_char = asmcp_pkg::CHR_O;
               asmcp_pkg::RPL_OU: tx_char = asmcp_pkg::CHR_U;
               asmcp_pkg::RPL_OL: tx_char = asmcp_pkg::CHR_L;
            endcase
         end
         2'b10: tx_char = asmcp_pkg::CHR_CR;
         2'b11: tx_char = asmcp_pkg::CHR_LF;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         t1_reg <= 1'b0;
         t2_reg <= 1'b0;
         t3_reg <= 1'b0;
         en_reg <= 1'b1;
      end else begin
         t1_reg <= i_tool_connected;
         t2_reg <= t1_reg;
         t3_reg <= t2_reg;
         if (t2_reg == t3_reg) begin
            en_reg <= !t3_reg;  // R03
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_reg <= asmcp_pkg::PS_KEY;
         cmd_reg <= asmcp_pkg::CMD_NONE;
         kw_reg <= '0;
         len_reg <= 4'h0;
         {bad_reg, sec_reg, neg_reg, neg1_reg, dot_reg, dig_reg, sgn_reg} <= 7'h00;
         mag_reg <= '0;
         mag1_reg <= '0;
         nfr_reg <= 3'h0;
      end else begin
         st_reg <= st_next;
         cmd_reg <= cmd_next;
         kw_reg <= kw_next;
         len_reg <= len_next;
         {bad_reg, sec_reg, neg_reg, neg1_reg} <= {bad_next, sec_next, neg_next, neg1_next};
         {dot_reg, dig_reg, sgn_reg} <= {dot_next, dig_next, sgn_next};
         mag_reg <= mag_next;
         mag1_reg <= mag1_next;
         nfr_reg <= nfr_next;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_x_pos <= 16'h0000;
         o_y_pos <= 16'h0000;
         o_pos_strobe <= 1'b0;
      end else begin
         o_pos_strobe <= set_x || set_y;
         if (set_x) begin
            o_x_pos <= val_x;  // R08 R10
         end
         if (set_y) begin
            o_y_pos <= val_a;  // R09 R10
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         busy_reg <= 1'b0;
         code_reg <= asmcp_pkg::RPL_OK;
         idx_reg <= 2'b00;
         nbit_reg <= 4'h0;
         bcnt_reg <= 16'h0000;
         shift_reg <= '1;
      end else if (tx_go) begin
         busy_reg <= 1'b1;  // R13
         code_reg <= reply_sel;
         idx_reg <= 2'b00;
         nbit_reg <= 4'h0;
         bcnt_reg <= 16'h0000;
         shift_reg <= {1'b1, tx_char, 1'b0};  // R05
      end else if (bit_end) begin
         bcnt_reg <= 16'h0000;
         if (nbit_reg == asmcp_pkg::FRAME_LAST) begin
            nbit_reg <= 4'h0;
            if (idx_reg == asmcp_pkg::REPLY_LAST) begin
               busy_reg <= 1'b0;
            end else begin
               idx_reg <= ld_idx;
               shift_reg <= {1'b1, tx_char, 1'b0};
            end
         end else begin
            nbit_reg <= nbit_reg + 4'h1;
            shift_reg <= {1'b1, shift_reg[9:1]};
         end
      end else if (busy_reg) begin
         bcnt_reg <= bcnt_reg + 16'h0001;
      end
   end

   assign o_tx = shift_reg[0];
   assign o_enabled = en_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   case_fold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R01
      rx_valid && en_reg && is_up && st_reg == asmcp_pkg::PS_KEY && kw_reg[39:32] == 8'h00
      |=> kw_reg[7:0] == ($past(rx_data) | asmcp_pkg::CASE_BIT))
      else $error("Upper case letter not folded into keyword.");
   msg_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R02
      line_done && too_long |-> reply_sel == asmcp_pkg::RPL_NO)
      else $error("Over long message not answered NO.");
   tool_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R03
      !en_reg |=> st_reg == asmcp_pkg::PS_KEY && !o_pos_strobe && !busy_reg || $past(busy_reg))
      else $error("Parser active while tool connected.");
   start_bit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R05
      tx_go |=> !o_tx [*8])
      else $error("Reply frame lacks a start bit.");
   start_ok_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R07
      line_done && cmd_reg == asmcp_pkg::CMD_START && !bad_reg && !too_long
      |-> reply_sel == asmcp_pkg::RPL_OK ##1 !o_pos_strobe && $stable(o_x_pos))
      else $error("Start handshake wrong.");
   x_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R08
      line_done && cmd_reg == asmcp_pkg::CMD_X && reply_sel == asmcp_pkg::RPL_OK
      |=> o_pos_strobe && o_x_pos == $past(val_a) && $stable(o_y_pos))
      else $error("X position not taken.");
   y_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R09
      line_done && cmd_reg == asmcp_pkg::CMD_Y && reply_sel == asmcp_pkg::RPL_OK
      |=> o_pos_strobe && o_y_pos == $past(val_a) && $stable(o_x_pos))
      else $error("Y position not taken.");
   xy_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R10
      line_done && cmd_reg == asmcp_pkg::CMD_XY && reply_sel == asmcp_pkg::RPL_OK
      |=> o_x_pos == $past(val_b) && o_y_pos == $past(val_a))
      else $error("Dual axis position not taken.");
   range_high_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
      line_done && cmd_reg == asmcp_pkg::CMD_X && !bad_reg && !too_long && hi_a
      |-> reply_sel == asmcp_pkg::RPL_OU ##1 $stable(o_x_pos))
      else $error("Out of range value accepted.");
   unknown_cmd_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R12
      line_done && bad_reg |-> reply_sel == asmcp_pkg::RPL_NO)
      else $error("Bad command not answered NO.");
   one_reply_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
      tx_go |=> busy_reg && code_reg == $past(reply_sel) && st_reg == asmcp_pkg::PS_KEY)
      else $error("Line end did not start one reply.");

endmodule

`default_nettype wire

// File: core/asmcp_pkg.sv
package asmcp_pkg;

   // Clock and serial line timing.
   localparam int unsigned CLK_HZ = 32'h0EE6_B280;
   localparam int unsigned BAUD_RATE = 32'h0003_E800;
   localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;

   // Message length: 64 bits hold eight characters, line end excluded.
   localparam logic [3:0] MAX_CHARS = 4'h8;

   // Positions are in units of 1/10000; full scale is one.
   localparam logic [17:0] POS_FULL = 18'h0_2710;
   localparam logic [17:0] DEC_BASE = 18'h0_000A;
   localparam logic [17:0] FRAC_W [4] = '{18'h0_03E8, 18'h0_0064, 18'h0_000A, 18'h0_0001};
   localparam logic [2:0] FRAC_DIGITS = 3'h4;

   // Characters.
   localparam logic [7:0] CHR_CR = 8'h0D;
   localparam logic [7:0] CHR_LF = 8'h0A;
   localparam logic [7:0] CHR_EQ = 8'h3D;
   localparam logic [7:0] CHR_SEMI = 8'h3B;
   localparam logic [7:0] CHR_DOT = 8'h2E;
   localparam logic [7:0] CHR_MINUS = 8'h2D;
   localparam logic [7:0] CHR_PLUS = 8'h2B;
   localparam logic [7:0] CHR_SPACE = 8'h20;
   localparam logic [7:0] CHR_UA = 8'h41;
   localparam logic [7:0] CHR_UZ = 8'h5A;
   localparam logic [7:0] CHR_LA = 8'h61;
   localparam logic [7:0] CHR_LZ = 8'h7A;
   localparam logic [7:0] CHR_D0 = 8'h30;
   localparam logic [7:0] CHR_D9 = 8'h39;
   localparam logic [7:0] CASE_BIT = 8'h20;
   localparam logic [7:0] CHR_O = 8'h4F;
   localparam logic [7:0] CHR_K = 8'h4B;
   localparam logic [7:0] CHR_N = 8'h4E;
   localparam logic [7:0] CHR_U = 8'h55;
   localparam logic [7:0] CHR_L = 8'h4C;

   // Keywords, right aligned in a five character window.
   localparam logic [39:0] KW_START = 40'h73_7461_7274;
   localparam logic [39:0] KW_X = 40'h00_0000_0078;
   localparam logic [39:0] KW_Y = 40'h00_0000_0079;
   localparam logic [39:0] KW_XY = 40'h00_0000_7879;

   // Transmit framing.
   localparam logic [3:0] FRAME_LAST = 4'h9;
   localparam logic [1:0] REPLY_LAST = 2'h3;
   localparam logic [3:0] DATA_BITS = 4'h8;

   typedef enum logic [1:0] {RPL_OK, RPL_NO, RPL_OU, RPL_OL} asmcp_reply_t;
   typedef enum logic [2:0] {CMD_NONE, CMD_START, CMD_X, CMD_Y, CMD_XY} asmcp_cmd_t;
   typedef enum logic [1:0] {PS_KEY, PS_NUM, PS_SKIP, PS_LF} asmcp_pstate_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asmcp_rxstate_t;

endpackage

// File: core/asmcp_uart_rx.sv
`timescale 1ns/100ps
`default_nettype none

module asmcp_uart_rx #(
   parameter int unsigned BAUD_DIV = asmcp_pkg::BIT_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_rx,
   output logic [7:0] o_data,
   output logic o_valid
);

   logic s1_reg, s2_reg, s3_reg, line_reg;
   asmcp_pkg::asmcp_rxstate_t st_reg;
   logic [15:0] cnt_reg;
   logic [3:0] nbit_reg;
   logic [7:0] sh_reg;

   wire cnt_end = (cnt_reg == 16'h0000);
   wire [15:0] full_bit = 16'(BAUD_DIV - 1);
   wire [15:0] half_bit = 16'(BAUD_DIV / 2);

   ////////////////////////////////////////////////////////////////////////
   // The line counts as changed once the second and third stages agree.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         line_reg <= 1'b1;
      end else begin
         s1_reg <= i_rx;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            line_reg <= s3_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Eight data bits, one stop bit, no parity; bad stop bits drop the byte.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_reg <= asmcp_pkg::RX_IDLE;
         cnt_reg <= 16'h0000;
         nbit_reg <= 4'h0;
         sh_reg <= 8'h00;
         o_data <= 8'h00;
         o_valid <= 1'b0;
      end else begin
         o_valid <= 1'b0;
         if (!cnt_end) begin
            cnt_reg <= cnt_reg - 16'h0001;
         end
         unique case (st_reg)
            asmcp_pkg::RX_IDLE: begin
               if (!line_reg) begin
                  st_reg <= asmcp_pkg::RX_START;
                  cnt_reg <= half_bit;
               end
            end
            asmcp_pkg::RX_START: begin
               if (cnt_end) begin
                  st_reg <= line_reg ? asmcp_pkg::RX_IDLE : asmcp_pkg::RX_DATA;
                  cnt_reg <= full_bit;
                  nbit_reg <= 4'h0;
               end
            end
            asmcp_pkg::RX_DATA: begin
               if (cnt_end) begin
                  sh_reg <= {line_reg, sh_reg[7:1]};
                  nbit_reg <= nbit_reg + 4'h1;
                  cnt_reg <= full_bit;
                  if (nbit_reg == asmcp_pkg::DATA_BITS - 4'h1) begin
                     st_reg <= asmcp_pkg::RX_STOP;
                  end
               end
            end
            asmcp_pkg::RX_STOP: begin
               if (cnt_end) begin
                  st_reg <= asmcp_pkg::RX_IDLE;
                  o_valid <= line_reg;
                  o_data <= sh_reg;
               end
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// File: testbench/asmcp_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module asmcp_host_model #(
   parameter int unsigned BIT = 16,
   parameter int unsigned GAP = 400
) (
   input wire logic i_clk,
   input wire logic i_tx,
   output logic o_rx
);
   logic [7:0] rx_q[$];
   logic [7:0] rx_byte;

   initial o_rx = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Sends one frame: start bit, eight data bits from the lowest, one stop bit.
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      @(posedge i_clk);
      #1;
      for (int i = 0; i < 10; i++) begin
         o_rx = f[i];
         repeat (BIT) @(posedge i_clk);
         #1;
      end
   endtask

   // Waits the command spacing, then sends the text and the line end.
   task automatic send_line(input string s);
      repeat (GAP) @(posedge i_clk);
      for (int i = 0; i < s.len(); i++) begin
         send_byte(s[i]);
      end
      send_byte(8'h0D);
      send_byte(8'h0A);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Collects reply bytes; a frame without a high stop bit is dropped.
   always begin
      @(negedge i_tx);
      repeat (BIT / 2) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge i_clk);
         rx_byte[i] = i_tx;
      end
      repeat (BIT) @(posedge i_clk);
      if (i_tx === 1'b1) begin
         rx_q.push_back(rx_byte);
      end
   end
endmodule

`default_nettype wire

// File: testbench/asmcp_parser_tb.sv
`timescale 1ns/100ps
`default_nettype none

module asmcp_parser_tb;
   localparam int unsigned BIT = 16;
   localparam logic [15:0] RPL_OK = 16'h4F4B;
   localparam logic [15:0] RPL_NO = 16'h4E4F;
   localparam logic [15:0] RPL_OU = 16'h4F55;
   localparam logic [15:0] RPL_OL = 16'h4F4C;
   logic i_clk, i_rst_n, i_tool_connected, strobe, enabled;
   wire logic rx, tx;
   logic [15:0] x_pos, y_pos;
   int failures, compares, strobes, s0;

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   asmcp_parser #(.BAUD_DIV(BIT)) i_asmcp_parser (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_rx(rx), .i_tool_connected(i_tool_connected), .o_tx(tx), .o_x_pos(x_pos),
      .o_y_pos(y_pos), .o_pos_strobe(strobe), .o_enabled(enabled));
   asmcp_host_model #(.BIT(BIT)) i_asmcp_host_model (.i_clk(i_clk), .i_tx(tx), .o_rx(rx));

   always @(posedge i_clk) if (strobe === 1'b1) strobes++;

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Sends a line, compares the one reply, and checks no second reply follows.
   task automatic run_cmd(input string s, input logic [15:0] code);
      logic [31:0] got;
      int n;
      i_asmcp_host_model.send_line(s);
      n = 0;
      while (i_asmcp_host_model.rx_q.size() < 4 && n < 3000) begin
         @(posedge i_clk);
         n++;
      end
      got = 32'h0000_0000;
      repeat (4) if (i_asmcp_host_model.rx_q.size() > 0)
         got = {got[23:0], i_asmcp_host_model.rx_q.pop_front()};
      check(got, {code, 16'h0D0A});
      repeat (BIT * 12) @(posedge i_clk);
      check(i_asmcp_host_model.rx_q.size(), 0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_handshake;
      s0 = strobes;
      run_cmd("START", RPL_OK);
      run_cmd("sTaRt", RPL_OK);
      check(strobes - s0, 0);
   endtask

   task automatic t_axes;
      s0 = strobes;
      run_cmd("x=0.5", RPL_OK);
      check(x_pos, 16'h1388);
      run_cmd("Y= -0.6", RPL_OK);
      check(y_pos, 16'hE890);
      check(x_pos, 16'h1388);
      run_cmd("xy=0;0", RPL_OK);
      check({x_pos, y_pos}, 32'h0000_0000);
      check(strobes - s0, 3);
   endtask

   task automatic t_range;
      run_cmd("x=1", RPL_OK);
      check(x_pos, 16'h2710);
      s0 = strobes;
      run_cmd("x=1.5", RPL_OU);
      run_cmd("y=-1.01", RPL_OL);
      run_cmd("xy=2;-2", RPL_OU);
      check({x_pos, y_pos}, 32'h2710_0000);
      check(strobes - s0, 0);
   endtask

   task automatic t_unknown;
      run_cmd("foo", RPL_NO);
      run_cmd("z=1", RPL_NO);
      run_cmd("", RPL_NO);
      run_cmd("x=0.12345", RPL_NO);
      run_cmd("x=-0.25", RPL_OK);
      check(x_pos, 16'hF63C);
   endtask

   task automatic t_tool;
      @(posedge i_clk);
      #1 i_tool_connected = 1'b1;
      repeat (8) @(posedge i_clk);
      check(enabled, 1'b0);
      i_asmcp_host_model.send_line("start");
      repeat (1200) @(posedge i_clk);
      check(i_asmcp_host_model.rx_q.size(), 0);
      #1 i_tool_connected = 1'b0;
      repeat (8) @(posedge i_clk);
      check(enabled, 1'b1);
      run_cmd("start", RPL_OK);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      failures = 0;
      compares = 0;
      strobes = 0;
      i_rst_n = 1'b0;
      i_tool_connected = 1'b0;
      repeat (2) @(posedge i_clk);
      #1 i_rst_n = 1'b1;
      @(posedge i_clk);
      #1;
      check({enabled, tx}, 2'b11);
      check({x_pos, y_pos}, 32'h0000_0000);
      t_handshake();
      t_axes();
      t_range();
      t_unknown();
      t_tool();
      stop_test();
   end

   initial begin
      #300000;
      failures++;
      stop_test();
   end
endmodule

`default_nettype wire
